// *** verilog/scan_tap_pkg.sv ***
// Purpose: shared types and constants of the scan test access port block
// Assumes: one direction of data flow, A pins are inputs, B pins outputs
// Notes:   instruction codes other than the capture pattern and the
//          all-ones bypass code are local choices
package scan_tap_pkg;

	// tap controller states, standard sixteen-state graph
	typedef enum logic [3:0] {
		TEST_LOGIC_RESET,
		RUN_TEST_IDLE,
		SELECT_DR,
		CAPTURE_DR,
		SHIFT_DR,
		EXIT1_DR,
		PAUSE_DR,
		EXIT2_DR,
		UPDATE_DR,
		SELECT_IR,
		CAPTURE_IR,
		SHIFT_IR,
		EXIT1_IR,
		PAUSE_IR,
		EXIT2_IR,
		UPDATE_IR
	} tap_state_t;

	////////////////////////////////////////////////////////////////////////
	// widths
	localparam int IR_WIDTH     = 8;
	localparam int PIN_COUNT    = 8;
	localparam int CTRL_WIDTH   = 3;
	localparam int BSR_WIDTH    = 3 * PIN_COUNT;
	localparam int STREAM_WIDTH = 3 * PIN_COUNT;

	////////////////////////////////////////////////////////////////////////
	// instruction register
	localparam logic [IR_WIDTH-1:0] IR_CAPTURE      = 8'h81;
	localparam logic [IR_WIDTH-1:0] INSTR_BYPASS    = 8'hFF;
	localparam logic [IR_WIDTH-1:0] INSTR_BOUNDARY  = 8'h82;
	localparam logic [IR_WIDTH-1:0] INSTR_CTRL_SCAN = 8'h87;
	localparam logic [IR_WIDTH-1:0] INSTR_RUN_TEST  = 8'h09;

	////////////////////////////////////////////////////////////////////////
	// boundary control register
	localparam logic [CTRL_WIDTH-1:0] OP_SIG_COUNT = 3'h7;
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET   = 3'h0;

	////////////////////////////////////////////////////////////////////////
	// signature feedback and stream buffering
	localparam logic [PIN_COUNT-1:0] SIG_TAPS_DEFAULT = 8'h1D;
	localparam int STREAM_DEPTH = 32;
	localparam int STALL_MARGIN = 4;

	// boundary register, sig holds the input cells and shifts out first
	typedef struct packed {
		logic [PIN_COUNT-1:0] cnt_hi;
		logic [PIN_COUNT-1:0] cnt_lo;
		logic [PIN_COUNT-1:0] sig;
	} bsr_t;

	// one step of the combined operation as seen by the system side
	typedef struct packed {
		logic [PIN_COUNT-1:0]   signature;
		logic [2*PIN_COUNT-1:0] count;
	} stream_word_t;

endpackage : scan_tap_pkg

// *** verilog/stream_fifo.sv ***
// Purpose: synchronous fifo with registered read data
// Assumes: DEPTH is a power of two so the pointers wrap by themselves
// Notes:   level counts the words held, including the output stage
`timescale 1ns/1ps
`default_nettype none

module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// filling side
	input  wire logic                      in_valid,
	output logic                           in_ready,
	input  wire logic [WIDTH-1:0]          in_data,
	// draining side
	output logic                           out_valid,
	input  wire logic                      out_ready,
	output logic [WIDTH-1:0]               out_data,
	// occupancy
	output logic [$clog2(DEPTH+2)-1:0]     level
);

	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH + 2);
	localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;

	wire logic        push = in_valid && in_ready;
	wire logic        load = (count != '0) && (!out_valid || out_ready);
	wire logic [AW:0] next_count = count + (AW + 1)'(push) - (AW + 1)'(load);

	assign in_ready = (count != FULL_COUNT);
	assign level    = LW'(count) + LW'(out_valid);

	// storage has no reset, the pointers, count and output stage do
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			out_valid <= 1'h0;
			out_data  <= '0;
		end else begin
			wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
			rd_ptr <= load ? rd_ptr + AW'(1) : rd_ptr;
			count  <= next_count;
			if (load) begin
				out_data <= mem[rd_ptr];
			end
			out_valid <= load || (out_valid && !out_ready);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	fill_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		(push && !load) |=> count == $past(count) + (AW + 1)'(1))
		else $error("fifo count did not rise on a lone push");
	out_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(out_valid && !out_ready) |=> out_valid && $stable(out_data))
		else $error("fifo output changed while stalled");
	full_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
		!in_ready);

endmodule : stream_fifo

`default_nettype wire

// *** verilog/scan_tap_signature_count.sv ***
// Purpose: boundary-scan tap with combined signature and binary count
// Assumes: tms and tdi are launched by the controller on falling tck
// Notes:   each run step is also streamed to the system clock domain;
//          a nearly full buffer holds the run step until it drains
`timescale 1ns/1ps
`default_nettype none

module scan_tap_signature_count
	import scan_tap_pkg::*;
#(
	parameter logic [PIN_COUNT-1:0] SIG_TAPS   = SIG_TAPS_DEFAULT,
	parameter int                   FIFO_DEPTH = STREAM_DEPTH
) (
	// system clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// test access port
	input  wire logic                 tck,
	input  wire logic                 tms,
	input  wire logic                 tdi,
	output logic                      tdo,
	output logic                      tdo_oe,
	// functional pins
	input  wire logic [PIN_COUNT-1:0] a_pin_in,
	output logic [PIN_COUNT-1:0]      b_pin_out,
	output logic                      b_pin_oe,
	// internal transceiver side
	output logic [PIN_COUNT-1:0]      core_in,
	// signature stream, system clock
	output logic                      sig_valid,
	input  wire logic                 sig_ready,
	output stream_word_t              sig_word
);

	localparam int LW = $clog2(FIFO_DEPTH + 2);
	localparam logic [LW-1:0] STALL_AT = LW'(FIFO_DEPTH - STALL_MARGIN);

	function automatic tap_state_t tap_next(input tap_state_t s,
		input logic m);
		case (s)
			TEST_LOGIC_RESET: tap_next = m ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
			RUN_TEST_IDLE:    tap_next = m ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_DR:        tap_next = m ? SELECT_IR : CAPTURE_DR;
			CAPTURE_DR:       tap_next = m ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR:         tap_next = m ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR:         tap_next = m ? UPDATE_DR : PAUSE_DR;
			PAUSE_DR:         tap_next = m ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR:         tap_next = m ? UPDATE_DR : SHIFT_DR;
			UPDATE_DR:        tap_next = m ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_IR:        tap_next = m ? TEST_LOGIC_RESET : CAPTURE_IR;
			CAPTURE_IR:       tap_next = m ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR:         tap_next = m ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR:         tap_next = m ? UPDATE_IR : PAUSE_IR;
			PAUSE_IR:         tap_next = m ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR:         tap_next = m ? UPDATE_IR : SHIFT_IR;
			UPDATE_IR:        tap_next = m ? SELECT_DR : RUN_TEST_IDLE;
			default:          tap_next = TEST_LOGIC_RESET;
		endcase
	endfunction : tap_next

	////////////////////////////////////////////////////////////////////////
	// tck domain reset: asserts at once, releases on a tck edge
	logic tck_rst_meta;
	logic tck_rst_n;

	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			tck_rst_meta <= 1'h0;
			tck_rst_n    <= 1'h0;
		end else begin
			tck_rst_meta <= 1'h1;
			tck_rst_n    <= tck_rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tap registers
	tap_state_t             state;
	logic [IR_WIDTH-1:0]    ir_shift;
	logic [IR_WIDTH-1:0]    ir_active;
	logic [CTRL_WIDTH-1:0]  ctrl_shift;
	logic [CTRL_WIDTH-1:0]  ctrl_active;
	logic                   bypass_bit;
	bsr_t                   bsr_shift;
	logic [PIN_COUNT-1:0]   cnt_hi_shadow;
	stream_word_t           word_hold;
	logic                   word_toggle;
	logic                   run_stall_meta;
	logic                   run_stall;
	logic                   stall_level;

	wire tap_state_t next_state = tap_next(state, tms);

	// instruction decode; unknown codes fall back to bypass
	wire logic sel_bsr    = (ir_active == INSTR_BOUNDARY);
	wire logic sel_ctrl   = (ir_active == INSTR_CTRL_SCAN);
	wire logic sel_bypass = !sel_bsr && !sel_ctrl;
	wire logic run_test   = (ir_active == INSTR_RUN_TEST);
	wire logic shifting   = (state == SHIFT_DR) || (state == SHIFT_IR);

	// the run only advances when the system side can take the result
	wire logic run_active = run_test && (state == RUN_TEST_IDLE) &&
		(ctrl_active == OP_SIG_COUNT);
	wire logic run_step   = run_active && !run_stall;

	// signature feedback, seed is whatever was scanned in before
	wire logic                 sig_fb   = ^(bsr_shift.sig & SIG_TAPS);
	wire logic [PIN_COUNT-1:0] sig_next =
		{bsr_shift.sig[PIN_COUNT-2:0], sig_fb} ^ a_pin_in;

	wire logic                 lo_carry = &bsr_shift.cnt_lo;
	wire logic [PIN_COUNT-1:0] lo_next  = bsr_shift.cnt_lo + PIN_COUNT'(1);
	wire logic [PIN_COUNT-1:0] hi_next  =
		bsr_shift.cnt_hi + PIN_COUNT'(lo_carry);

	wire bsr_t bsr_shifted = bsr_t'({tdi, bsr_shift[BSR_WIDTH-1:1]});

	wire logic tdo_bit = (state == SHIFT_IR) ? ir_shift[0] :
		sel_bsr ? bsr_shift[0] :
		sel_ctrl ? ctrl_shift[0] : bypass_bit;

	////////////////////////////////////////////////////////////////////////
	// rising tck: state, capture and shift
	always_ff @(posedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			state <= TEST_LOGIC_RESET;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			ir_shift <= IR_CAPTURE;
		end else if (state == CAPTURE_IR) begin
			ir_shift <= IR_CAPTURE;
		end else if (state == SHIFT_IR) begin
			ir_shift <= {tdi, ir_shift[IR_WIDTH-1:1]};
		end
	end

	always_ff @(posedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			bypass_bit <= 1'h0;
			ctrl_shift <= CTRL_RESET;
		end else begin
			if (sel_bypass && state == CAPTURE_DR) begin
				bypass_bit <= 1'h0;
			end else if (sel_bypass && state == SHIFT_DR) begin
				bypass_bit <= tdi;
			end
			if (sel_ctrl && state == SHIFT_DR) begin
				ctrl_shift <= {tdi, ctrl_shift[CTRL_WIDTH-1:1]};
			end
		end
	end

	// capture-dr leaves the boundary register as it is, for read-back
	always_ff @(posedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			bsr_shift <= '0;
		end else if (sel_bsr && state == SHIFT_DR) begin
			bsr_shift <= bsr_shifted;
		end else if (run_step) begin
			bsr_shift.sig    <= sig_next;
			bsr_shift.cnt_lo <= lo_next;
			bsr_shift.cnt_hi <= hi_next;
		end
	end

	// word_hold stays put for a whole tck period after each toggle
	always_ff @(posedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			word_hold   <= '0;
			word_toggle <= 1'h0;
		end else if (run_step) begin
			word_hold   <= {sig_next, hi_next, lo_next};
			word_toggle <= !word_toggle;
		end
	end

	always_ff @(posedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			run_stall_meta <= 1'h0;
			run_stall      <= 1'h0;
		end else begin
			run_stall_meta <= stall_level;
			run_stall      <= run_stall_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// falling tck: update stages and pins
	always_ff @(negedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			ir_active   <= INSTR_BYPASS;
			ctrl_active <= CTRL_RESET;
		end else if (state == TEST_LOGIC_RESET) begin
			ir_active   <= INSTR_BYPASS;
			ctrl_active <= CTRL_RESET;
		end else if (state == UPDATE_IR) begin
			ir_active <= ir_shift;
		end else if (state == UPDATE_DR && sel_ctrl) begin
			ctrl_active <= ctrl_shift;
		end
	end

	always_ff @(negedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			core_in       <= '0;
			b_pin_out     <= '0;
			cnt_hi_shadow <= '0;
		// follows the run cells outside idle too, so the leaving step shows
		end else if ((state == UPDATE_DR && sel_bsr) ||
			(run_test && ctrl_active == OP_SIG_COUNT)) begin
			core_in       <= bsr_shift.sig;
			b_pin_out     <= bsr_shift.cnt_lo;
			cnt_hi_shadow <= bsr_shift.cnt_hi;
		end
	end

	always_ff @(negedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			tdo      <= 1'h0;
			tdo_oe   <= 1'h0;
			b_pin_oe <= 1'h0;
		end else begin
			tdo      <= tdo_bit;
			tdo_oe   <= shifting;
			b_pin_oe <= run_test;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// crossing to the system clock
	logic                       tog_meta;
	logic                       tog_sync;
	logic                       tog_seen;
	logic                       fifo_in_ready;
	logic [LW-1:0]              fifo_level;

	wire logic pending = (tog_sync != tog_seen);
	wire logic push    = pending && fifo_in_ready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tog_meta    <= 1'h0;
			tog_sync    <= 1'h0;
			tog_seen    <= 1'h0;
			stall_level <= 1'h0;
		end else begin
			tog_meta    <= word_toggle;
			tog_sync    <= tog_meta;
			tog_seen    <= push ? tog_sync : tog_seen;
			stall_level <= (fifo_level >= STALL_AT);
		end
	end

	// margin covers words already in flight when the stall takes hold
	stream_fifo #(
		.WIDTH (STREAM_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) word_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (pending),
		.in_ready  (fifo_in_ready),
		.in_data   (word_hold),
		.out_valid (sig_valid),
		.out_ready (sig_ready),
		.out_data  (sig_word),
		.level     (fifo_level)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	ir_capture_a: assert property (
		@(posedge tck) disable iff (!tck_rst_n)
		state == CAPTURE_IR |=> ir_shift == IR_CAPTURE)
		else $error("capture pattern not loaded");
	ir_update_a: assert property (
		@(posedge tck) disable iff (!tck_rst_n)
		state == UPDATE_IR |=> ir_active == $past(ir_shift))
		else $error("instruction not updated");
	bypass_zero_a: assert property (
		@(posedge tck) disable iff (!tck_rst_n)
		(state == CAPTURE_DR && sel_bypass) |=> !bypass_bit)
		else $error("bypass bit did not capture zero");
	tdo_enable_a: assert property (
		@(posedge tck) disable iff (!tck_rst_n)
		shifting |-> tdo_oe)
		else $error("tdo not enabled in shift state");
	tdo_release_a: assert property (
		@(posedge tck) disable iff (!tck_rst_n)
		(state == EXIT1_IR || state == EXIT1_DR) |-> !tdo_oe)
		else $error("tdo still driven in exit1");
	count_step_a: assert property (
		@(posedge tck) disable iff (!tck_rst_n)
		run_step |=> {bsr_shift.cnt_hi, bsr_shift.cnt_lo} ==
			$past({bsr_shift.cnt_hi, bsr_shift.cnt_lo}) + 16'h0001)
		else $error("16-bit count did not advance by one");
	pin_follow_a: assert property (
		@(posedge tck) disable iff (!tck_rst_n)
		run_step |=> b_pin_out == bsr_shift.cnt_lo && b_pin_oe)
		else $error("output pins do not show the count");
	core_follow_a: assert property (
		@(posedge tck) disable iff (!tck_rst_n)
		run_step |=> core_in == $past(sig_next))
		else $error("shadow latches do not show the signature");
	run_gate_a: assert property (
		@(posedge tck) disable iff (!tck_rst_n)
		(!run_step && !(sel_bsr && state == SHIFT_DR)) |=>
			$stable(bsr_shift))
		else $error("boundary register moved outside the run");
	reset_exit_a: assert property (
		@(posedge tck) disable iff (!tck_rst_n)
		(state == TEST_LOGIC_RESET && !tms) |=> state == RUN_TEST_IDLE)
		else $error("tms low did not leave test-logic-reset");
	stream_push_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		pending |-> ##[0:8] !pending)
		else $error("run step not taken into the buffer");

	bypass_scan_c: cover property (@(posedge tck) disable iff (!tck_rst_n)
		state == SHIFT_DR && sel_bypass);
	count_wrap_c: cover property (@(posedge tck) disable iff (!tck_rst_n)
		run_step && lo_carry);
	run_stall_c: cover property (@(posedge tck) disable iff (!tck_rst_n)
		run_active && run_stall);

endmodule : scan_tap_signature_count

`default_nettype wire

// *** testbench/tap_ctrl_model.sv ***
// Purpose: behavioural boundary-scan controller driving the tap
// Assumes: tck stands low between calls, so it is still outside frames
// Notes:   tms and tdi move just after the fall, tdo is read before rise
`timescale 1ns/1ps
`default_nettype none

module tap_ctrl_model (
	// tap drive
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	// tap return
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	int   rise_moves;
	logic held;

	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		rise_moves = 0;
	end

	////////////////////////////////////////////////////////////////////////
	// one full tck period of 125 ns
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#61.5;
		o = tdo;
		held = tdo;
		tck = 1'b1;
		#1;
		// an enabled tdo must not move on the rise
		if (tdo_oe && tdo !== held)
			rise_moves++;
		#61.5;
		tck = 1'b0;
		#1;
	endtask : step

	// tdi is ignored outside shifts, so toggle it to expose false sampling
	task automatic idle_step(input logic m);
		logic o;
		step(m, ~tdi, o);
	endtask : idle_step

endmodule : tap_ctrl_model
`default_nettype wire

// *** testbench/test_scan_tap_signature_count.sv ***
// Purpose: self-checking bench for the tap with signature and count
// Assumes: default feedback taps and a 32-word stream buffer
// Notes:   stream words are noted in a queue by the driver and
//          compared in order by a watcher on the system clock
`timescale 1ns/1ps
`default_nettype none

module test_scan_tap_signature_count
	import scan_tap_pkg::*;
;
	logic                 clk;
	logic                 rst_n;
	logic                 tck;
	logic                 tms;
	logic                 tdi;
	logic                 tdo;
	logic                 tdo_oe;
	logic [PIN_COUNT-1:0] a_pin_in;
	logic [PIN_COUNT-1:0] b_pin_out;
	logic                 b_pin_oe;
	logic [PIN_COUNT-1:0] core_in;
	logic                 sig_valid;
	logic                 sig_ready;
	logic [1:0]           ready_mode;
	stream_word_t         sig_word;
	stream_word_t         st;
	stream_word_t         last_exp;
	stream_word_t         exp_q[$];
	bsr_t                 seed;
	logic [23:0]          dout;
	logic [7:0]           cap;
	int                   miscompares;
	int                   samples_checked;
	int                   words_seen;
	int                   cycles;
	int                   w0;

	scan_tap_signature_count #(
		.SIG_TAPS   (SIG_TAPS_DEFAULT),
		.FIFO_DEPTH (STREAM_DEPTH)
	) dut (
		.clk       (clk),
		.rst_n     (rst_n),
		.tck       (tck),
		.tms       (tms),
		.tdi       (tdi),
		.tdo       (tdo),
		.tdo_oe    (tdo_oe),
		.a_pin_in  (a_pin_in),
		.b_pin_out (b_pin_out),
		.b_pin_oe  (b_pin_oe),
		.core_in   (core_in),
		.sig_valid (sig_valid),
		.sig_ready (sig_ready),
		.sig_word  (sig_word)
	);

	tap_ctrl_model ctrl (
		.tck    (tck),
		.tms    (tms),
		.tdi    (tdi),
		.tdo    (tdo),
		.tdo_oe (tdo_oe)
	);

	always #2.5 clk = ~clk;

	// sink ready: random, held low or held high
	always @(posedge clk)
		sig_ready <= ready_mode[1] ? 1'($urandom) : ready_mode[0];

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("checked %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	function automatic stream_word_t next_word(stream_word_t w, logic [7:0] a);
		stream_word_t r;
		r.signature = {w.signature[6:0], ^(w.signature & SIG_TAPS_DEFAULT)} ^ a;
		r.count = w.count + 16'h0001;
		return r;
	endfunction : next_word

	// tms follows bits, lsb first, one tck period each
	task automatic walk(input int n, input logic [7:0] bits);
		for (int i = 0; i < n; i++)
			ctrl.idle_step(bits[i]);
	endtask : walk

	// both scans start in Select-DR and end in Run-Test/Idle
	task automatic ir_scan(input logic [7:0] code);
		logic o;
		walk(3, 8'h01);
		check(24'(tdo_oe), 24'h1);
		for (int i = 0; i < 8; i++) begin
			ctrl.step(i == 7, code[i], o);
			cap[i] = o;
		end
		check(24'(tdo_oe), 24'h0);
		check(24'(cap), 24'(IR_CAPTURE));
		walk(2, 8'h01);
	endtask : ir_scan

	task automatic dr_scan(input int n, input logic [23:0] din);
		logic o;
		dout = '0;
		walk(2, 8'h00);
		check(24'(tdo_oe), 24'h1);
		for (int i = 0; i < n; i++) begin
			ctrl.step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		check(24'(tdo_oe), 24'h0);
		walk(2, 8'h01);
	endtask : dr_scan

	// every rise in idle under run test is one step unless stalled, the leaving one too
	task automatic run_steps(input int n, input logic free, input logic last);
		logic [7:0] a;
		for (int i = 0; i < n; i++) begin
			a = 8'($urandom);
			@(posedge clk) a_pin_in <= a;
			st = next_word(st, a);
			exp_q.push_back(st);
			@(negedge clk);
			ctrl.idle_step(i == n - 1 ? last : 1'b0);
			if (free) begin
				check(24'(core_in), 24'(st.signature));
				check(24'(b_pin_out), 24'(st.count[7:0]));
				check(24'(b_pin_oe), 24'h1);
			end
		end
	endtask : run_steps

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (rst_n && sig_valid === 1'b1 && sig_ready) begin
			if (exp_q.size() == 0)
				check(sig_word, 'x);
			else begin
				last_exp = exp_q.pop_front();
				words_seen++;
				check(sig_word, last_exp);
			end
		end
	end

	// whole run is near 6200 clk, so this only trips on a hang
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		ready_mode = 2'h2;
		a_pin_in = 8'h00;
		miscompares = 0;
		samples_checked = 0;
		words_seen = 0;
		cycles = 0;
		void'($urandom(75614));
		repeat (2) @(posedge clk);
		walk(2, 8'hFF);
		check(24'({tdo_oe, b_pin_oe, sig_valid, core_in}), 24'h0);
		@(posedge clk) rst_n <= 1'b1;
		// two rises release the tap, one more in reset, then tms low
		walk(5, 8'h17);
		// bypass: one zero captured ahead of the shifted bits
		ir_scan(INSTR_BYPASS);
		walk(1, 8'h01);
		dr_scan(3, 24'h5);
		check(24'(dout[2:0]), 24'h2);
		walk(1, 8'h01);
		ir_scan(INSTR_CTRL_SCAN);
		walk(1, 8'h01);
		dr_scan(3, 24'(OP_SIG_COUNT));
		// low count byte near the top so the carry reaches the high byte
		seed = {8'($urandom), 8'hE0 | 8'($urandom & 15), 8'($urandom)};
		walk(1, 8'h01);
		ir_scan(INSTR_BOUNDARY);
		walk(1, 8'h01);
		dr_scan(24, seed);
		check(24'(core_in), 24'(seed.sig));
		check(24'(b_pin_out), 24'(seed.cnt_lo));
		st = {seed.sig, seed.cnt_hi, seed.cnt_lo};
		walk(1, 8'h01);
		ir_scan(INSTR_RUN_TEST);
		run_steps(30, 1'b1, 1'b0);
		repeat (20) @(posedge clk);
		w0 = words_seen;
		// sink stalls: the buffer fills and run steps are held
		@(posedge clk) ready_mode <= 2'h0;
		run_steps(40, 1'b0, 1'b1);
		@(posedge clk) ready_mode <= 2'h1;
		repeat (100) @(posedge clk);
		check(24'(words_seen - w0 >= 28 && words_seen - w0 <= 32), 24'h1);
		check(24'(exp_q.size() > 0), 24'h1);
		exp_q.delete();
		st = last_exp;
		// held steps leave the boundary cells at the last word sent
		ir_scan(INSTR_BOUNDARY);
		walk(1, 8'h01);
		seed = 24'($urandom);
		dr_scan(24, seed);
		check(dout, {st.count, st.signature});
		check(24'(core_in), 24'(seed.sig));
		// the scanned value is the new start of the run
		st = {seed.sig, seed.cnt_hi, seed.cnt_lo};
		walk(1, 8'h01);
		ir_scan(INSTR_RUN_TEST);
		check(24'(b_pin_oe), 24'h1);
		run_steps(1, 1'b1, 1'b1);
		walk(4, 8'h0F);
		check(24'({b_pin_oe, tdo_oe}), 24'h0);
		repeat (20) @(posedge clk);
		check(24'(exp_q.size()), 24'h0);
		check(24'(ctrl.rise_moves), 24'h0);
		wrap_up();
	end

endmodule : test_scan_tap_signature_count
`default_nettype wire
